// *** rtl/mct_pkg.sv ***
/*
  Package of the multi-channel timer: register offsets, field layouts,
  channel and slave modes, reset values and the variant feature table.
  Assumes a single timer clock and a plain address/strobe register port.
*/
package mct_pkg;

  // ****************************************************************
  // Variants and geometry
  // ****************************************************************
  typedef enum logic [2:0] {
    MCT_ADV, MCT_WIDE, MCT_NARROW, MCT_DUAL, MCT_SINGLE, MCT_BASIC
  } mct_variant_type;

  localparam int MCT_NCH = 4;
  localparam int MCT_AW = 8;
  localparam int MCT_DW = 32;
  localparam int MCT_PSC_W = 16;
  localparam int MCT_DT_W = 8;
  localparam int MCT_ST_W = 6;
  localparam int MCT_DMA_W = 5;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] MCT_A_CTRL = 8'h00;
  localparam logic [7:0] MCT_A_STATUS = 8'h04;
  localparam logic [7:0] MCT_A_MASK = 8'h08;
  localparam logic [7:0] MCT_A_CNT = 8'h0c;
  localparam logic [7:0] MCT_A_PSC = 8'h10;
  localparam logic [7:0] MCT_A_ARR = 8'h14;
  localparam logic [7:0] MCT_A_DEAD = 8'h18;
  localparam logic [7:0] MCT_A_DMAEN = 8'h1c;
  localparam logic [7:0] MCT_A_CHCFG = 8'h20;
  localparam logic [7:0] MCT_A_CCR0 = 8'h30;
  localparam logic [7:0] MCT_A_CCR_STEP = 8'h04;

  // Reset values and counter masks
  localparam logic [31:0] MCT_MASK_WIDE = 32'hffffffff;
  localparam logic [31:0] MCT_MASK_NARROW = 32'h0000ffff;
  localparam logic [31:0] MCT_ARR_RST = 32'hffffffff;
  localparam logic [15:0] MCT_PSC_RST = 16'h0000;
  localparam logic [7:0] MCT_DT_RST = 8'h00;

  // Status bit positions; channel flags follow the update flag
  localparam int MCT_ST_UPD = 0;
  localparam int MCT_ST_CC = 1;
  localparam int MCT_ST_TRG = 5;
  localparam int MCT_DMA_UPD = 0;
  localparam int MCT_DMA_CC = 1;

  // Control register layout, bit 0 is enable
  typedef struct packed {
    logic hall_en;
    logic [1:0] slave;
    logic freeze;
    logic opm;
    logic center;
    logic dir_down;
    logic enable;
  } mct_ctrl_type;

  // Per-channel configuration nibble
  typedef struct packed {
    logic pol;
    logic [2:0] mode;
  } mct_chcfg_type;

  localparam logic [2:0] MCT_M_OFF = 3'h0;
  localparam logic [2:0] MCT_M_CAP_RISE = 3'h1;
  localparam logic [2:0] MCT_M_CAP_FALL = 3'h2;
  localparam logic [2:0] MCT_M_TOGGLE = 3'h3;
  localparam logic [2:0] MCT_M_PWM = 3'h4;
  localparam logic [2:0] MCT_M_PWM_INV = 3'h5;
  localparam logic [2:0] MCT_M_LOW = 3'h6;
  localparam logic [2:0] MCT_M_HIGH = 3'h7;

  localparam logic [1:0] MCT_SLV_OFF = 2'h0;
  localparam logic [1:0] MCT_SLV_TRIG = 2'h1;
  localparam logic [1:0] MCT_SLV_EXT = 2'h2;
  localparam logic [1:0] MCT_SLV_ENC = 2'h3;

  // ****************************************************************
  // Variant feature table
  // ****************************************************************
  function automatic int mct_nch(mct_variant_type v);
    case (v)
      MCT_DUAL: return 2;
      MCT_SINGLE: return 1;
      MCT_BASIC: return 0;
      default: return MCT_NCH;
    endcase
  endfunction

  function automatic logic mct_wide(mct_variant_type v);
    return v == MCT_WIDE;
  endfunction

  // Advanced variant keeps the full general-purpose feature set
  function automatic logic mct_full(mct_variant_type v);
    return v == MCT_ADV || v == MCT_WIDE || v == MCT_NARROW;
  endfunction

  function automatic logic mct_dma(mct_variant_type v);
    return mct_full(v) || v == MCT_BASIC;
  endfunction

endpackage

// *** rtl/mct_timer.sv ***
/*
  Multi-channel timer: prescaled auto-reload counter, up to four
  capture/compare channels, complementary outputs with dead time,
  encoder and hall inputs, sync link, DMA requests and an interrupt.
  Assumes trig_in and debug_halt come from logic on clk; ch_in are pins.
*/
// Decided for this implementation: the address-and-strobe port and the address map.
// Functional notes
// - Wide variant counts on 32 bits, all other variants on 16 bits.
// - A 16-bit prescaler divides the clock by 1 up to 65536.
// - Full and advanced count up, down or center; reduced ones only up.
// - Full and advanced variants have four channels, each capture, compare, PWM, one-pulse.
// - PWM runs edge-aligned or center-aligned.
// - Advanced variant drives complementary outputs with programmable dead time.
// - Advanced PWM reaches every duty from fully off to fully on.
// - Trigger link in and out lets timers start together or chain.
// - Full and advanced variants raise a DMA request per channel event.
// - Full variants decode quadrature encoder inputs into up or down steps.
// - Full variants take three hall sensor inputs.
// - Counter stops while debug halt is high and freezing is selected.
// - Reduced variants have two or one channels and no DMA.
// - Basic variant is a 16-bit upcounter without channels but with DMA.
// - Reduced variants can start on a trigger or run alone.
// - Advanced variant has the general-purpose feature set too.
`timescale 1ns/1ps
module mct_timer
  import mct_pkg::*;
#(
  parameter mct_variant_type VARIANT = MCT_ADV
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [MCT_AW-1:0] addr,
  input wire logic [MCT_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [MCT_DW-1:0] rdata,
  input wire logic [MCT_NCH-1:0] ch_in,
  input wire logic debug_halt,
  input wire logic trig_in,
  output logic [MCT_NCH-1:0] oc_out,
  output logic [MCT_NCH-1:0] oc_n_out,
  output logic trig_out,
  output logic [MCT_DMA_W-1:0] dma_req,
  output logic irq
);

  localparam int NCH = mct_nch(VARIANT);
  localparam logic FULL = mct_full(VARIANT);
  localparam logic DMA = mct_dma(VARIANT);
  localparam logic COMPL = VARIANT == MCT_ADV;
  localparam logic [31:0] CMASK = mct_wide(VARIANT) ? MCT_MASK_WIDE : MCT_MASK_NARROW;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [MCT_NCH-1:0] s1_ff, s2_ff, s3_ff, flt_ff, flt_prev_ff, trig_prev_ff;
  logic [MCT_NCH-1:0] nxt_s1_ff, nxt_s2_ff, nxt_s3_ff, nxt_flt_ff;
  logic nxt_trig_prev_ff, trig_rise, hall_chg;

  // A pin change counts only once stages two and three agree
  always_comb begin
    nxt_s1_ff = ch_in;
    nxt_s2_ff = s1_ff;
    nxt_s3_ff = s2_ff;
    nxt_flt_ff = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & flt_ff);
    nxt_trig_prev_ff = trig_in;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      flt_ff <= '0;
      flt_prev_ff <= '0;
      trig_prev_ff <= '0;
    end else begin
      s1_ff <= nxt_s1_ff;
      s2_ff <= nxt_s2_ff;
      s3_ff <= nxt_s3_ff;
      flt_ff <= nxt_flt_ff;
      flt_prev_ff <= flt_ff;
      trig_prev_ff <= {3'h0, nxt_trig_prev_ff};
    end
  end

  assign trig_rise = trig_in & ~trig_prev_ff[0];

  // ****************************************************************
  // Register state
  // ****************************************************************
  mct_ctrl_type ctrl_ff, nxt_ctrl_ff;
  mct_chcfg_type [MCT_NCH-1:0] chcfg_ff, nxt_chcfg_ff;
  logic [MCT_ST_W-1:0] st_ff, nxt_st_ff, mask_ff, nxt_mask_ff, ev;
  logic [31:0] cnt_ff, nxt_cnt_ff, arr_ff, nxt_arr_ff;
  logic [31:0] ccr_ff [MCT_NCH];
  logic [31:0] nxt_ccr_ff [MCT_NCH];
  logic [MCT_PSC_W-1:0] psc_ff, nxt_psc_ff, psc_cnt_ff, nxt_psc_cnt_ff;
  logic [MCT_DT_W-1:0] dead_ff, nxt_dead_ff;
  logic [MCT_DMA_W-1:0] dmaen_ff, nxt_dmaen_ff, dma_ff, nxt_dma_ff;
  logic [MCT_DW-1:0] rdata_ff, nxt_rdata_ff;
  logic dir_dn_ff, nxt_dir_dn_ff, irq_ff, nxt_irq_ff, trig_out_ff, nxt_trig_out_ff;
  logic [MCT_NCH-1:0] cap_ev, cmp_ev;
  logic [1:0] slv;
  logic run, psc_tick, step, step_dn, upd, down, center, cnt_wr;

  // Hall mode folds the first three inputs into one change event
  assign hall_chg = FULL && ctrl_ff.hall_en && (^flt_ff[2:0] != ^flt_prev_ff[2:0]);
  assign cnt_wr = wr && (addr == MCT_A_CNT);

  // ****************************************************************
  // Prescaler and count steps
  // ****************************************************************
  // Encoder mode exists only on full variants; others fall back to internal
  always_comb begin
    slv = (!FULL && ctrl_ff.slave == MCT_SLV_ENC) ? MCT_SLV_OFF : ctrl_ff.slave;
    run = ctrl_ff.enable && !(ctrl_ff.freeze && debug_halt);
    nxt_psc_cnt_ff = psc_cnt_ff;
    psc_tick = 1'b0;
    step = 1'b0;
    step_dn = 1'b0;
    if (run && (slv == MCT_SLV_OFF || slv == MCT_SLV_TRIG)) begin
      if (psc_cnt_ff >= psc_ff) begin
        nxt_psc_cnt_ff = '0;
        psc_tick = 1'b1;
      end else begin
        nxt_psc_cnt_ff = psc_cnt_ff + 16'h0001;
      end
    end
    case (slv)
      MCT_SLV_EXT: step = run && trig_rise;
      MCT_SLV_ENC: begin
        // A-leads-B counts up; both inputs changing at once is ignored
        step = run && ((flt_ff[0] ^ flt_prev_ff[0]) ^ (flt_ff[1] ^ flt_prev_ff[1]));
        step_dn = (flt_ff[0] ^ flt_prev_ff[0]) ? (flt_ff[0] == flt_ff[1])
                                                : (flt_ff[0] != flt_ff[1]);
      end
      default: step = psc_tick;
    endcase
    // Writing the prescaler restarts the division cleanly
    if (wr && addr == MCT_A_PSC) begin
      nxt_psc_cnt_ff = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      psc_cnt_ff <= '0;
    end else begin
      psc_cnt_ff <= nxt_psc_cnt_ff;
    end
  end

  // ****************************************************************
  // Counter, registers, flags, DMA and read port
  // ****************************************************************
  always_comb begin
    nxt_ctrl_ff = ctrl_ff;
    nxt_chcfg_ff = chcfg_ff;
    nxt_mask_ff = mask_ff;
    nxt_cnt_ff = cnt_ff;
    nxt_arr_ff = arr_ff;
    nxt_psc_ff = psc_ff;
    nxt_dead_ff = dead_ff;
    nxt_dmaen_ff = dmaen_ff;
    nxt_ccr_ff = ccr_ff;
    nxt_dir_dn_ff = dir_dn_ff;
    nxt_rdata_ff = '0;
    upd = 1'b0;
    center = FULL && ctrl_ff.center && slv != MCT_SLV_ENC;
    if (slv == MCT_SLV_ENC) begin
      down = step_dn;
    end else if (center) begin
      down = dir_dn_ff;
    end else begin
      down = FULL && ctrl_ff.dir_down;
    end
    if (step) begin
      nxt_dir_dn_ff = down;
      if (!down) begin
        if (cnt_ff >= arr_ff) begin
          upd = 1'b1;
          if (center) begin
            nxt_dir_dn_ff = 1'b1;
            nxt_cnt_ff = (arr_ff - 32'h1) & CMASK;
          end else begin
            nxt_cnt_ff = '0;
          end
        end else begin
          nxt_cnt_ff = (cnt_ff + 32'h1) & CMASK;
        end
      end else begin
        if (cnt_ff == '0) begin
          upd = 1'b1;
          if (center) begin
            nxt_dir_dn_ff = 1'b0;
            nxt_cnt_ff = 32'h1;
          end else begin
            nxt_cnt_ff = arr_ff;
          end
        end else begin
          nxt_cnt_ff = (cnt_ff - 32'h1) & CMASK;
        end
      end
    end
    // One-pulse stops at the update; a trigger starts a waiting timer
    if (upd && ctrl_ff.opm) begin
      nxt_ctrl_ff.enable = 1'b0;
    end
    if (slv == MCT_SLV_TRIG && trig_rise) begin
      nxt_ctrl_ff.enable = 1'b1;
    end
    // Software writes; register data written by software wins over counting
    if (wr) begin
      if (addr == MCT_A_CTRL) begin
        nxt_ctrl_ff = mct_ctrl_type'(wdata[7:0]);
      end else if (addr == MCT_A_MASK) begin
        nxt_mask_ff = wdata[MCT_ST_W-1:0];
      end else if (addr == MCT_A_CNT) begin
        nxt_cnt_ff = wdata & CMASK;
      end else if (addr == MCT_A_PSC) begin
        nxt_psc_ff = wdata[MCT_PSC_W-1:0];
      end else if (addr == MCT_A_ARR) begin
        nxt_arr_ff = wdata & CMASK;
      end else if (addr == MCT_A_DEAD) begin
        nxt_dead_ff = wdata[MCT_DT_W-1:0];
      end else if (addr == MCT_A_DMAEN) begin
        nxt_dmaen_ff = wdata[MCT_DMA_W-1:0];
      end else if (addr == MCT_A_CHCFG) begin
        nxt_chcfg_ff = wdata[15:0];
      end
    end
    for (int i = 0; i < MCT_NCH; i++) begin
      if (wr && addr == MCT_A_CCR0 + 8'(i) * MCT_A_CCR_STEP) begin
        nxt_ccr_ff[i] = wdata & CMASK;
      end
      if (cap_ev[i]) begin
        nxt_ccr_ff[i] = cnt_ff;
      end
    end
    // Sticky flags: an event in the clearing cycle survives
    ev = '0;
    ev[MCT_ST_UPD] = upd;
    ev[MCT_ST_CC +: MCT_NCH] = cap_ev | cmp_ev;
    ev[MCT_ST_TRG] = trig_rise | hall_chg;
    nxt_st_ff = st_ff;
    if (wr && addr == MCT_A_STATUS) begin
      nxt_st_ff = st_ff & ~wdata[MCT_ST_W-1:0];
    end
    nxt_st_ff = nxt_st_ff | ev;
    nxt_irq_ff = |(nxt_st_ff & nxt_mask_ff);
    nxt_trig_out_ff = upd;
    nxt_dma_ff = '0;
    if (DMA) begin
      nxt_dma_ff[MCT_DMA_UPD] = upd && dmaen_ff[MCT_DMA_UPD];
      nxt_dma_ff[MCT_DMA_CC +: MCT_NCH] = (cap_ev | cmp_ev)
                                          & dmaen_ff[MCT_DMA_CC +: MCT_NCH];
    end
    // Read port; unmapped addresses read zero
    if (rd) begin
      if (addr == MCT_A_CTRL) begin
        nxt_rdata_ff = {24'h0, ctrl_ff};
      end else if (addr == MCT_A_STATUS) begin
        nxt_rdata_ff = {26'h0, st_ff};
      end else if (addr == MCT_A_MASK) begin
        nxt_rdata_ff = {26'h0, mask_ff};
      end else if (addr == MCT_A_CNT) begin
        nxt_rdata_ff = cnt_ff;
      end else if (addr == MCT_A_PSC) begin
        nxt_rdata_ff = {16'h0, psc_ff};
      end else if (addr == MCT_A_ARR) begin
        nxt_rdata_ff = arr_ff;
      end else if (addr == MCT_A_DEAD) begin
        nxt_rdata_ff = {24'h0, dead_ff};
      end else if (addr == MCT_A_DMAEN) begin
        nxt_rdata_ff = {27'h0, dmaen_ff};
      end else if (addr == MCT_A_CHCFG) begin
        nxt_rdata_ff = {15'h0, dir_dn_ff, chcfg_ff};
      end else begin
        for (int i = 0; i < MCT_NCH; i++) begin
          if (addr == MCT_A_CCR0 + 8'(i) * MCT_A_CCR_STEP) begin
            nxt_rdata_ff = ccr_ff[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= '0;
      chcfg_ff <= '0;
      st_ff <= '0;
      mask_ff <= '0;
      cnt_ff <= '0;
      arr_ff <= MCT_ARR_RST & CMASK;
      psc_ff <= MCT_PSC_RST;
      dead_ff <= MCT_DT_RST;
      dmaen_ff <= '0;
      ccr_ff <= '{default: '0};
      dir_dn_ff <= 1'b0;
      rdata_ff <= '0;
      irq_ff <= 1'b0;
      trig_out_ff <= 1'b0;
      dma_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl_ff;
      chcfg_ff <= nxt_chcfg_ff;
      st_ff <= nxt_st_ff;
      mask_ff <= nxt_mask_ff;
      cnt_ff <= nxt_cnt_ff;
      arr_ff <= nxt_arr_ff;
      psc_ff <= nxt_psc_ff;
      dead_ff <= nxt_dead_ff;
      dmaen_ff <= nxt_dmaen_ff;
      ccr_ff <= nxt_ccr_ff;
      dir_dn_ff <= nxt_dir_dn_ff;
      rdata_ff <= nxt_rdata_ff;
      irq_ff <= nxt_irq_ff;
      trig_out_ff <= nxt_trig_out_ff;
      dma_ff <= nxt_dma_ff;
    end
  end

  assign rdata = rdata_ff;
  assign irq = irq_ff;
  assign trig_out = trig_out_ff;
  assign dma_req = dma_ff;

  // ****************************************************************
  // Channels: capture, compare, PWM and dead time
  // ****************************************************************
  for (genvar i = 0; i < MCT_NCH; i++) begin : g_ch
    mct_chcfg_type cfg;
    logic act, outm, rise, fall, ref_ff, nxt_ref_ff, oc_ff, nxt_oc_ff, ocn_ff, nxt_ocn_ff;
    logic [MCT_DT_W-1:0] dt_ff, nxt_dt_ff;

    assign cfg = chcfg_ff[i];
    assign act = i < NCH;
    assign outm = cfg.mode >= MCT_M_TOGGLE;
    assign rise = flt_ff[i] & ~flt_prev_ff[i];
    assign fall = ~flt_ff[i] & flt_prev_ff[i];
    // Hall change captures on the first channel in either capture mode
    assign cap_ev[i] = act && ((cfg.mode == MCT_M_CAP_RISE && rise)
                       || (cfg.mode == MCT_M_CAP_FALL && fall)
                       || (i == 0 && hall_chg && !outm && cfg.mode != MCT_M_OFF));
    assign cmp_ev[i] = act && outm && step && cnt_ff == ccr_ff[i];

    // Reference waveform, then the dead-time gap on complementary pairs
    always_comb begin
      case (cfg.mode)
        MCT_M_TOGGLE: nxt_ref_ff = ref_ff ^ cmp_ev[i];
        MCT_M_PWM: nxt_ref_ff = cnt_ff < ccr_ff[i];
        MCT_M_PWM_INV: nxt_ref_ff = !(cnt_ff < ccr_ff[i]);
        MCT_M_HIGH: nxt_ref_ff = 1'b1;
        default: nxt_ref_ff = 1'b0;
      endcase
      nxt_dt_ff = dt_ff;
      nxt_oc_ff = 1'b0;
      nxt_ocn_ff = 1'b0;
      if (act && outm) begin
        if (!COMPL) begin
          nxt_oc_ff = nxt_ref_ff ^ cfg.pol;
        end else if (nxt_ref_ff != ref_ff && dead_ff != '0) begin
          nxt_dt_ff = dead_ff - 8'h01;
          nxt_oc_ff = cfg.pol;
          nxt_ocn_ff = cfg.pol;
        end else if (dt_ff != '0) begin
          nxt_dt_ff = dt_ff - 8'h01;
          nxt_oc_ff = cfg.pol;
          nxt_ocn_ff = cfg.pol;
        end else begin
          nxt_oc_ff = nxt_ref_ff ^ cfg.pol;
          nxt_ocn_ff = !nxt_ref_ff ^ cfg.pol;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        ref_ff <= 1'b0;
        dt_ff <= '0;
        oc_ff <= 1'b0;
        ocn_ff <= 1'b0;
      end else begin
        ref_ff <= nxt_ref_ff;
        dt_ff <= nxt_dt_ff;
        oc_ff <= nxt_oc_ff;
        ocn_ff <= nxt_ocn_ff;
      end
    end

    assign oc_out[i] = oc_ff;
    assign oc_n_out[i] = ocn_ff;

    a_dead_gap: assert property (@(posedge clk) disable iff (reset)
      (COMPL && act && outm && nxt_ref_ff != ref_ff && dead_ff != '0) |=> (oc_ff == ocn_ff))
      else $error("complementary pair not held inactive during dead time");
    a_pwm_full: assert property (@(posedge clk) disable iff (reset)
      (cfg.mode == MCT_M_PWM && ccr_ff[i] > arr_ff && cnt_ff <= arr_ff) |=> ref_ff)
      else $error("full duty PWM reference dropped");
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_cnt_width: assert property (@(posedge clk) disable iff (reset)
    (cnt_ff & ~CMASK) == '0)
    else $error("counter exceeds variant width");
  a_psc_divide: assert property (@(posedge clk) disable iff (reset)
    (psc_tick && psc_ff == 16'h0003 && !wr)
      ##1 (run && !wr && (slv == MCT_SLV_OFF || slv == MCT_SLV_TRIG))[*4] |-> psc_tick)
    else $error("prescaler by four missed its tick");
  a_up_only: assert property (@(posedge clk) disable iff (reset)
    !FULL |-> !dir_dn_ff)
    else $error("reduced variant counted down");
  a_upd_reload: assert property (@(posedge clk) disable iff (reset)
    (step && !down && !center && cnt_ff >= arr_ff && !cnt_wr)
      |=> (cnt_ff == '0 && st_ff[MCT_ST_UPD] && trig_out_ff))
    else $error("up overflow did not reload and flag update");
  a_capture_latch: assert property (@(posedge clk) disable iff (reset)
    cap_ev[0] |=> (ccr_ff[0] == $past(cnt_ff) && st_ff[MCT_ST_CC]))
    else $error("capture did not latch counter");
  a_freeze_hold: assert property (@(posedge clk) disable iff (reset)
    (ctrl_ff.freeze && debug_halt && !cnt_wr) |=> $stable(cnt_ff))
    else $error("counter moved while frozen");
  a_no_dma: assert property (@(posedge clk) disable iff (reset)
    !DMA |-> dma_ff == '0)
    else $error("DMA request from variant without DMA");
  a_trig_start: assert property (@(posedge clk) disable iff (reset)
    (slv == MCT_SLV_TRIG && trig_rise && !(wr && addr == MCT_A_CTRL)) |=> ctrl_ff.enable)
    else $error("trigger did not start the counter");

endmodule // mct_timer

// *** bench/mct_far_side.sv ***
/*
  Far-side model: a quadrature encoder on ch_in[1:0], one phase per step.
  Assumes step comes from the bench on clk; each cycle it stays high is one step.
*/
`timescale 1ns/1ps
module mct_far_side
  import mct_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic step,
  output logic [MCT_NCH-1:0] ch_in
);
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;
  // Advance one quadrature phase per step
  always_comb begin
    nxt_phase = step ? phase_ff + 2'h1 : phase_ff;
  end
  always_ff @(posedge clk) begin
    phase_ff <= reset ? 2'h0 : nxt_phase;
  end
  // A leads B so the walk counts up; ch_in[3:2] held low
  assign ch_in = {2'h0, phase_ff[1], phase_ff[1] ^ phase_ff[0]};
endmodule // mct_far_side

// *** bench/testbench.sv ***
/*
  Self-checking bench of the advanced timer variant.
  Assumes a 25 MHz clock and the register map of the package.
*/
`timescale 1ns/1ps
module testbench;
  import mct_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic debug_halt = 1'b0;
  logic trig_in = 1'b0;
  logic step = 1'b0;
  logic [31:0] rdata, d0, d1;
  logic [3:0] ch_in, oc_out, oc_n_out;
  logic [4:0] dma_req;
  logic trig_out, irq;
  int mismatches = 0;
  int samples_checked = 0;
  int hi, bad, ups;
  logic [7:0] row_a [6] = '{MCT_A_PSC, MCT_A_ARR, MCT_A_DEAD, MCT_A_DMAEN, MCT_A_MASK, 8'h2c};
  logic [31:0] row_d [6] = '{32'h1ffff, 32'h12345, 32'h1ff, 32'h1f, 32'h3f, 32'h5};
  logic [31:0] row_e [6] = '{32'hffff, 32'h2345, 32'hff, 32'h1f, 32'h3f, 32'h0};
  always #20 clk = ~clk;
  mct_timer i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ch_in(ch_in), .debug_halt(debug_halt), .trig_in(trig_in),
    .oc_out(oc_out), .oc_n_out(oc_n_out), .trig_out(trig_out), .dma_req(dma_req), .irq(irq));
  mct_far_side i_far (.clk(clk), .reset(reset), .step(step), .ch_in(ch_in));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Strobe is released one edge before the next request to avoid double drives
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  // Settle, then count high output, equal pair and update pulses over 48 clocks
  task automatic sample48;
    repeat (8) @(posedge clk);
    hi = 0;
    bad = 0;
    ups = 0;
    repeat (48) begin
      @(posedge clk);
      #1 hi += oc_out[0];
      bad += (oc_out[0] === oc_n_out[0]);
      ups += trig_out;
    end
    @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung wait
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus_rd(MCT_A_ARR, d0);
    chk(d0, 32'hffff);
    bus_rd(MCT_A_PSC, d0);
    chk(d0, 32'h0);
    // Register rows, unmapped address last
    for (int i = 0; i < 6; i++) begin
      bus_wr(row_a[i], row_d[i]);
      bus_rd(row_a[i], d0);
      chk(d0, row_e[i]);
    end
    // Reload at ARR=2, update flag, trigger, dma and interrupt
    bus_wr(MCT_A_PSC, 32'h0);
    bus_wr(MCT_A_ARR, 32'h2);
    bus_wr(MCT_A_MASK, 32'h1);
    bus_wr(MCT_A_STATUS, 32'h3f);
    bus_wr(MCT_A_CTRL, 32'h1);
    hi = 0;
    for (int i = 0; i < 20 && hi == 0; i++) begin
      @(posedge clk);
      #1 hi = trig_out;
    end
    chk(hi, 1);
    chk(dma_req[0], 1'b1);
    chk(irq, 1'b1);
    bus_wr(MCT_A_MASK, 32'h0);
    chk(irq, 1'b0);
    // Edge PWM, duty one in four, complementary pair without dead time
    bus_wr(MCT_A_DEAD, 32'h0);
    bus_wr(MCT_A_ARR, 32'h3);
    bus_wr(MCT_A_CCR0, 32'h1);
    bus_wr(MCT_A_CHCFG, {29'h0, MCT_M_PWM});
    sample48();
    chk(hi, 12);
    chk(bad, 0);
    chk(ups, 12);
    // One dead cycle at each edge of a half duty wave: pair low twice a period
    bus_wr(MCT_A_DEAD, 32'h1);
    bus_wr(MCT_A_CCR0, 32'h2);
    sample48();
    chk(hi, 12);
    chk(bad, 24);
    // Compare above the reload value is fully on, zero is fully off
    bus_wr(MCT_A_DEAD, 32'h0);
    bus_wr(MCT_A_CCR0, 32'h4);
    sample48();
    chk(hi, 48);
    bus_wr(MCT_A_CCR0, 32'h0);
    sample48();
    chk(hi, 0);
    chk(bad, 0);
    // Center-aligned turns at both ends: period of six, two updates each
    bus_wr(MCT_A_CTRL, 32'h5);
    sample48();
    chk(ups, 16);
    // Down counting reloads at zero and reads back as down
    bus_wr(MCT_A_CTRL, 32'h3);
    sample48();
    chk(ups, 12);
    bus_rd(MCT_A_CHCFG, d0);
    chk(d0[16], 1'b1);
    bus_wr(MCT_A_CTRL, 32'h1);
    // Prescale by four: two steps in eight clocks
    bus_wr(MCT_A_CHCFG, 32'h0);
    bus_wr(MCT_A_ARR, 32'hffff);
    bus_wr(MCT_A_PSC, 32'h3);
    bus_rd(MCT_A_CNT, d0);
    repeat (6) @(posedge clk);
    bus_rd(MCT_A_CNT, d1);
    chk(d1 - d0, 32'h2);
    // Debug halt with freezing selected holds the count
    debug_halt <= 1'b1;
    bus_wr(MCT_A_CTRL, 32'h11);
    bus_rd(MCT_A_CNT, d0);
    repeat (6) @(posedge clk);
    bus_rd(MCT_A_CNT, d1);
    chk(d1, d0);
    debug_halt <= 1'b0;
    // Capture on a rising channel 0 edge
    bus_wr(MCT_A_PSC, 32'h0);
    bus_wr(MCT_A_CHCFG, {29'h0, MCT_M_CAP_RISE});
    bus_wr(MCT_A_STATUS, 32'h3f);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (8) @(posedge clk);
    bus_rd(MCT_A_STATUS, d0);
    chk(d0[MCT_ST_CC], 1'b1);
    // Encoder mode: four quadrature edges count four up
    bus_wr(MCT_A_CHCFG, 32'h0);
    bus_wr(MCT_A_CTRL, 32'h61);
    bus_wr(MCT_A_CNT, 32'h0);
    step <= 1'b1;
    repeat (4) @(posedge clk);
    step <= 1'b0;
    repeat (10) @(posedge clk);
    bus_rd(MCT_A_CNT, d0);
    chk(d0, 32'h4);
    // Trigger mode: a rising link input starts the stopped timer and flags it
    bus_wr(MCT_A_CTRL, 32'h20);
    trig_in <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
    bus_rd(MCT_A_CTRL, d0);
    chk(d0[0], 1'b1);
    bus_rd(MCT_A_STATUS, d0);
    chk(d0[MCT_ST_TRG], 1'b1);
    end_of_test();
  end
endmodule // testbench
